/* hdl/bus_master_pkg.sv */
// Shared constants and types for the core system bus master port
package bus_master_pkg;
  // Bus field widths and positions
  localparam int ADDR_HI = 35;
  localparam int ADDR_LO = 2;
  localparam int LINE_LO = 4;
  localparam int WORD_W = 32;
  localparam int BE_W = 4;
  localparam int BEATS = 4;
  localparam int LINE_DATA_W = WORD_W * BEATS;
  localparam int LINE_BE_W = BE_W * BEATS;

  // Byte enable patterns
  localparam logic [BE_W-1:0] BE_ALL = 4'hF;
  localparam logic [LINE_BE_W-1:0] LINE_BE_ALL = 16'hFFFF;

  // Beat counts and word positions
  localparam logic [2:0] BEATS_SINGLE = 3'h1;
  localparam logic [2:0] BEATS_BURST = 3'h4;
  localparam logic [2:0] BEAT_FIRST = 3'h0;
  localparam logic [2:0] BEAT_LAST = 3'h3;
  localparam logic [1:0] WRITE_BURST_START = 2'h0;

  // Read sampling delay after the first address is taken, minus one
  localparam logic [1:0] RD_DELAY_SINGLE = 2'h0;
  localparam logic [1:0] RD_DELAY_BURST = 2'h1;
  localparam logic [1:0] RD_DELAY_NONE = 2'h0;

  // Transaction sequencer states, Gray coded along the usual path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b11,
    ST_FLUSH = 2'b10
  } xact_state_e;
endpackage : bus_master_pkg

/* hdl/wrap_order.sv */
// Word index generator for wrapping burst read orders
`timescale 1ns/10ps
module wrap_order (
  // Burst start word and beat number
  input wire logic [1:0] start,
  input wire logic [1:0] beat,
  // Order choice: high selects sub-block order
  input wire logic subblock,
  // Word index on the bus for this beat
  output logic [1:0] index
);
  // Sequential wraps modulo four, sub-block flips bits of the start
  always_comb begin
    if (subblock) begin
      index = start ^ beat;
    end else begin
      index = start + beat;
    end
  end
endmodule : wrap_order

/* hdl/write_error_window.sv */
// Catches the write error answer one clock after each data accept
`timescale 1ns/10ps
module write_error_window (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data accept seen and the word it carried
  input wire logic take,
  input wire logic [1:0] take_index,
  // Error input from the bus
  input wire logic write_bus_error,
  // Window open, then the answer
  output logic pending,
  output logic done_valid,
  output logic done_error,
  output logic [1:0] done_index
);
  logic [1:0] index_q;

  // Error is only meaningful in the clock after the accept
  always_ff @(posedge clk) begin
    if (rst) begin
      pending <= 1'b0;
      index_q <= 2'h0;
      done_valid <= 1'b0;
      done_error <= 1'b0;
      done_index <= 2'h0;
    end else begin
      pending <= take;
      index_q <= take_index;
      done_valid <= pending;
      done_error <= pending & write_bus_error;
      done_index <= index_q;
    end
  end
endmodule : write_error_window

/* hdl/core_system_bus_master.sv */
// Core side master of the pipelined system bus: single and burst transfers
`timescale 1ns/10ps
module core_system_bus_master (
  // Clock and synchronous reset
  input wire logic clk,
  input wire logic rst,
  // Core request: one read or one write buffer drain at a time
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_instr,
  input wire logic req_cacheable,
  input wire logic [bus_master_pkg::ADDR_HI:bus_master_pkg::ADDR_LO] req_addr,
  input wire logic [bus_master_pkg::BE_W-1:0] req_be,
  input wire logic [bus_master_pkg::LINE_DATA_W-1:0] req_wdata,
  input wire logic [bus_master_pkg::LINE_BE_W-1:0] req_wbe,
  // Core response, one pulse per word
  output logic resp_valid,
  output logic resp_write,
  output logic [1:0] resp_index,
  output logic [bus_master_pkg::WORD_W-1:0] resp_data,
  output logic resp_error,
  // Address bus
  output logic [bus_master_pkg::ADDR_HI:bus_master_pkg::ADDR_LO] bus_address,
  output logic [bus_master_pkg::BE_W-1:0] byte_lane_enables,
  output logic address_valid_out,
  input wire logic address_accept_ready,
  output logic write_not_read,
  output logic instruction_fetch_flag,
  output logic burst_indicator,
  output logic burst_first_beat,
  output logic burst_last_beat,
  input wire logic subblock_order_select,
  // Read data bus
  input wire logic [bus_master_pkg::WORD_W-1:0] read_data_in,
  input wire logic read_data_valid,
  input wire logic read_bus_error,
  // Write data bus
  output logic [bus_master_pkg::WORD_W-1:0] write_data_out,
  input wire logic write_data_accept,
  input wire logic write_bus_error
);
  bus_master_pkg::xact_state_e state;
  bus_master_pkg::xact_state_e next_state;
  logic [bus_master_pkg::ADDR_HI:bus_master_pkg::LINE_LO] line_q;
  logic [1:0] start_q;
  logic sblock_q;
  logic is_write;
  logic is_burst;
  logic instr_q;
  logic [bus_master_pkg::BE_W-1:0] rd_be_q;
  logic [bus_master_pkg::LINE_DATA_W-1:0] wdata_q;
  logic [bus_master_pkg::LINE_BE_W-1:0] wbe_q;
  logic [2:0] n_beats;
  logic [2:0] a_cnt;
  logic [2:0] d_cnt;
  logic [2:0] a_nx;
  logic [2:0] d_nx;
  logic wd_active;
  logic [1:0] wd_word;
  logic rd_armed;
  logic [1:0] rd_delay;
  logic [bus_master_pkg::BEATS-1:0] req_wen;
  logic [bus_master_pkg::BEATS-1:0] wen_q;
  logic accept;
  logic addr_take;
  logic rd_take;
  logic wd_take;
  logic req_burst;
  logic [1:0] req_word0;
  logic [2:0] req_nbeats;
  logic [1:0] ord_a_idx;
  logic [1:0] ord_d_idx;
  logic [1:0] a_word;
  logic [1:0] wd_next_word;
  logic [1:0] req_rd_start;
  logic wr_pend;
  logic wr_done_valid;
  logic wr_done_error;
  logic [1:0] wr_done_index;

  // k-th enabled word of a write buffer; shared by address and data paths
  function automatic logic [1:0] nth_set(input logic [3:0] en, input logic [2:0] k);
    logic [2:0] seen;
    logic [1:0] r;
    seen = 3'h0;
    r = 2'h0;
    for (int i = 0; i < bus_master_pkg::BEATS; i++) begin
      if (en[i]) begin
        if (seen == k) begin
          r = 2'(i);
        end
        seen = seen + 3'h1;
      end
    end
    return r;
  endfunction : nth_set

  // Word enables from the byte enables of each buffered word
  for (genvar w = 0; w < bus_master_pkg::BEATS; w++) begin : g_wen
    assign req_wen[w] = |req_wbe[w*bus_master_pkg::BE_W +: bus_master_pkg::BE_W];
    assign wen_q[w] = |wbe_q[w*bus_master_pkg::BE_W +: bus_master_pkg::BE_W];
  end

  // Handshake events seen this clock
  assign accept = req_valid & req_ready;
  assign addr_take = address_valid_out & address_accept_ready;
  assign rd_take = rd_armed & (rd_delay == bus_master_pkg::RD_DELAY_NONE) & read_data_valid;
  assign wd_take = wd_active & write_data_accept;
  assign a_nx = a_cnt + 3'h1;
  assign d_nx = d_cnt + 3'h1;
  assign req_rd_start = req_addr[bus_master_pkg::LINE_LO-1:bus_master_pkg::ADDR_LO];

  // Shape of a new request: a write goes as a burst only for a full buffer, a read when cacheable
  always_comb begin
    req_burst = req_write ? (req_wbe == bus_master_pkg::LINE_BE_ALL) : req_cacheable;
    req_nbeats = req_burst ? bus_master_pkg::BEATS_BURST : bus_master_pkg::BEATS_SINGLE;
    req_word0 = req_rd_start;
    if (req_write) begin
      req_nbeats = 3'h0;
      for (int i = 0; i < bus_master_pkg::BEATS; i++) begin
        req_nbeats = req_nbeats + {2'h0, req_wen[i]};
      end
      req_word0 = req_burst ? bus_master_pkg::WRITE_BURST_START : nth_set(req_wen, 3'h0);
    end
  end

  // Read word order for the next address and for the current data beat
  wrap_order u_ord_addr (
    .start(start_q),
    .beat(a_nx[1:0]),
    .subblock(sblock_q),
    .index(ord_a_idx)
  );

  wrap_order u_ord_data (
    .start(start_q),
    .beat(d_cnt[1:0]),
    .subblock(sblock_q),
    .index(ord_d_idx)
  );

  // Word on the bus for the next address beat and the next data beat
  always_comb begin
    if (!is_write) begin
      a_word = ord_a_idx;
    end else if (is_burst) begin
      a_word = a_nx[1:0];
    end else begin
      a_word = nth_set(wen_q, a_nx);
    end
    wd_next_word = is_burst ? d_nx[1:0] : nth_set(wen_q, d_nx);
  end

  // Request fields kept for the whole transaction
  always_ff @(posedge clk) begin
    if (rst) begin
      line_q <= '0;
      start_q <= 2'h0;
      sblock_q <= 1'b0;
      is_write <= 1'b0;
      is_burst <= 1'b0;
      instr_q <= 1'b0;
      rd_be_q <= '0;
      wdata_q <= '0;
      wbe_q <= '0;
      n_beats <= 3'h0;
    end else if (accept) begin
      line_q <= req_addr[bus_master_pkg::ADDR_HI:bus_master_pkg::LINE_LO];
      start_q <= req_rd_start;
      sblock_q <= subblock_order_select;
      is_write <= req_write;
      is_burst <= req_burst;
      instr_q <= req_instr & ~req_write;
      rd_be_q <= req_be;
      wdata_q <= req_wdata;
      wbe_q <= req_wbe;
      n_beats <= req_nbeats;
    end
  end

  // Sequencer: addresses, then remaining data, then the last error window
  always_comb begin
    next_state = state;
    case (state)
      bus_master_pkg::ST_IDLE: begin
        if (accept) next_state = bus_master_pkg::ST_ADDR;
      end
      bus_master_pkg::ST_ADDR: begin
        if (addr_take && a_nx == n_beats) next_state = bus_master_pkg::ST_DATA;
      end
      bus_master_pkg::ST_DATA: begin
        if (d_cnt == n_beats) next_state = bus_master_pkg::ST_FLUSH;
      end
      bus_master_pkg::ST_FLUSH: begin
        if (!wr_pend) next_state = bus_master_pkg::ST_IDLE;
      end
      default: next_state = bus_master_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= bus_master_pkg::ST_IDLE;
      req_ready <= 1'b0;
    end else begin
      state <= next_state;
      req_ready <= (next_state == bus_master_pkg::ST_IDLE);
    end
  end

  // Address phase; each next address goes out once ready takes the current one, without waiting for data
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_address <= '0;
      byte_lane_enables <= '0;
      address_valid_out <= 1'b0;
      write_not_read <= 1'b0;
      instruction_fetch_flag <= 1'b0;
      burst_indicator <= 1'b0;
      burst_first_beat <= 1'b0;
      burst_last_beat <= 1'b0;
      a_cnt <= 3'h0;
    end else if (accept) begin
      bus_address <=
        {req_addr[bus_master_pkg::ADDR_HI:bus_master_pkg::LINE_LO], req_word0};
      byte_lane_enables <= req_write ?
        req_wbe[req_word0*bus_master_pkg::BE_W +: bus_master_pkg::BE_W] :
        (req_burst ? bus_master_pkg::BE_ALL : req_be);
      address_valid_out <= 1'b1;
      write_not_read <= req_write;
      instruction_fetch_flag <= req_instr & ~req_write;
      burst_indicator <= req_burst;
      burst_first_beat <= req_burst;
      burst_last_beat <= 1'b0;
      a_cnt <= bus_master_pkg::BEAT_FIRST;
    end else if (addr_take) begin
      a_cnt <= a_nx;
      burst_first_beat <= 1'b0;
      if (a_nx == n_beats) begin
        address_valid_out <= 1'b0;
        write_not_read <= 1'b0;
        instruction_fetch_flag <= 1'b0;
        burst_indicator <= 1'b0;
        burst_last_beat <= 1'b0;
      end else begin
        bus_address <= {line_q, a_word};
        byte_lane_enables <= is_write ?
          wbe_q[a_word*bus_master_pkg::BE_W +: bus_master_pkg::BE_W] :
          (is_burst ? bus_master_pkg::BE_ALL : rd_be_q);
        burst_last_beat <= is_burst & (a_nx == bus_master_pkg::BEAT_LAST);
      end
    end
  end

  // Read sampling start: one clock after ready for singles, two for bursts
  always_ff @(posedge clk) begin
    if (rst || accept) begin
      rd_armed <= 1'b0;
      rd_delay <= bus_master_pkg::RD_DELAY_NONE;
    end else if (addr_take && a_cnt == bus_master_pkg::BEAT_FIRST && !is_write) begin
      rd_armed <= 1'b1;
      rd_delay <= is_burst ? bus_master_pkg::RD_DELAY_BURST
                           : bus_master_pkg::RD_DELAY_SINGLE;
    end else if (rd_take && d_nx == n_beats) begin
      rd_armed <= 1'b0;
    end else if (rd_armed && rd_delay != bus_master_pkg::RD_DELAY_NONE) begin
      rd_delay <= rd_delay - 2'h1;
    end
  end

  // Write data: first word with the address, next word after each accept
  always_ff @(posedge clk) begin
    if (rst) begin
      wd_active <= 1'b0;
      wd_word <= 2'h0;
      write_data_out <= '0;
    end else if (accept) begin
      wd_active <= req_write;
      wd_word <= req_word0;
      write_data_out <=
        req_wdata[req_word0*bus_master_pkg::WORD_W +: bus_master_pkg::WORD_W];
    end else if (wd_take) begin
      if (d_nx == n_beats) begin
        wd_active <= 1'b0;
      end else begin
        wd_word <= wd_next_word;
        write_data_out <=
          wdata_q[wd_next_word*bus_master_pkg::WORD_W +: bus_master_pkg::WORD_W];
      end
    end
  end

  // Data beats completed; low read valid simply stretches the wait
  always_ff @(posedge clk) begin
    if (rst || accept) begin
      d_cnt <= 3'h0;
    end else if (rd_take || wd_take) begin
      d_cnt <= d_nx;
    end
  end

  // Write errors arrive one clock after their accept
  write_error_window u_wr_err (
    .clk(clk),
    .rst(rst),
    .take(wd_take),
    .take_index(wd_word),
    .write_bus_error(write_bus_error),
    .pending(wr_pend),
    .done_valid(wr_done_valid),
    .done_error(wr_done_error),
    .done_index(wr_done_index)
  );

  // Responses to the core; read error travels with its own word
  always_ff @(posedge clk) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_write <= 1'b0;
      resp_index <= 2'h0;
      resp_data <= '0;
      resp_error <= 1'b0;
    end else begin
      resp_valid <= rd_take | wr_done_valid;
      resp_write <= wr_done_valid;
      resp_index <= rd_take ? ord_d_idx : wr_done_index;
      resp_data <= rd_take ? read_data_in : '0;
      resp_error <= rd_take ? read_bus_error : wr_done_error;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_addr_wait;
    address_valid_out && !address_accept_ready;
  endsequence
  sequence s_addr_take;
    address_valid_out && address_accept_ready;
  endsequence
  sequence s_burst_rd_start;
    s_addr_take ##0 burst_first_beat && !write_not_read;
  endsequence

  AST_ADDR_HOLD: assert property (s_addr_wait |=> address_valid_out && $stable(bus_address)
    && $stable(byte_lane_enables)) else $error("address changed before ready");
  AST_ADDR_AFTER_REQ: assert property (req_valid && req_ready |=> address_valid_out)
    else $error("no address valid after request");
  AST_SINGLE_INSTR: assert property (address_valid_out && !burst_indicator &&
    instruction_fetch_flag |-> !write_not_read && instr_q && !is_burst)
    else $error("fetch flag on wrong single read");
  AST_WRITE_FLAG: assert property (address_valid_out |-> write_not_read == is_write)
    else $error("write flag mismatch");
  AST_SINGLE_RD_LAT: assert property (s_addr_take ##0 !burst_indicator && !write_not_read
    |=> rd_armed && rd_delay == 2'h0) else $error("single read sampling late");
  AST_BURST_RD_LAT: assert property (s_burst_rd_start |=> rd_delay == 2'h1
    ##1 rd_armed && rd_delay == 2'h0) else $error("burst read sampling wrong clock");
  AST_WDATA_HOLD: assert property (wd_active && !write_data_accept |=> wd_active &&
    $stable(write_data_out)) else $error("write data changed before accept");
  AST_BWR_START: assert property (address_valid_out && burst_first_beat &&
    write_not_read |-> bus_address[3:2] == 2'h0 && burst_indicator)
    else $error("burst write start not zero");
  AST_BURST_ORDER: assert property (s_addr_take ##0 burst_indicator &&
    !write_not_read && !burst_last_beat |=> bus_address[3:2] == (sblock_q ? start_q ^ a_cnt[1:0]
    : start_q + a_cnt[1:0])) else $error("burst read word order wrong");
  AST_BURST_LINE: assert property (address_valid_out && burst_indicator |->
    bus_address[35:4] == line_q && byte_lane_enables == 4'hF)
    else $error("burst left its block");
  AST_MARKERS: assert property (burst_last_beat |-> burst_indicator && a_cnt == 3'h3 &&
    !burst_first_beat) else $error("last marker not on fourth address");
  AST_SINGLE_FLAGS: assert property (address_valid_out && !burst_indicator |->
    !burst_first_beat && !burst_last_beat) else $error("burst marker on single");
  AST_BURST_INSTR: assert property (address_valid_out && burst_indicator &&
    !write_not_read |-> instruction_fetch_flag == instr_q) else $error("refill fetch flag wrong");
  AST_BURST_WRITE_FULL: assert property (address_valid_out && write_not_read |->
    burst_indicator == (wbe_q == 16'hFFFF)) else $error("burst write choice wrong");
endmodule : core_system_bus_master

/* verif/bus_far_end.sv */
// Far side model: takes addresses, returns read words, takes write data
`timescale 1ns/10ps
module bus_far_end (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pacing and fault choice from the bench
  input wire logic slow,
  input wire logic err_en,
  input wire logic [1:0] err_idx,
  // Address bus
  input wire logic [35:2] bus_address,
  input wire logic address_valid_out,
  input wire logic write_not_read,
  output logic address_accept_ready,
  // Read data bus
  output logic [31:0] read_data_in,
  output logic read_data_valid,
  output logic read_bus_error,
  // Write data bus
  input wire logic [31:0] write_data_out,
  output logic write_data_accept,
  output logic write_bus_error
);
  logic [35:2] rqa[$];
  int rqt[$];
  logic [35:2] wq[$];
  logic [65:0] wlog[$];
  logic tog;
  logic go;
  int cyc;

  // Read word follows from its address, so the bench can predict it
  function automatic logic [31:0] rword(input logic [35:2] a);
    return 32'h5A00_0000 ^ a[33:2];
  endfunction : rword

  // Quiet outputs before the first reset edge
  initial begin
    address_accept_ready = 1'b0;
    read_data_in = 32'h0;
    read_data_valid = 1'b0;
    read_bus_error = 1'b0;
    write_data_accept = 1'b0;
    write_bus_error = 1'b0;
  end

  // Queues and outputs move together; outputs change only after an edge
  always @(posedge clk) begin
    if (rst) begin
      rqa.delete();
      rqt.delete();
      wq.delete();
      cyc = 0;
      tog = 1'b0;
      address_accept_ready <= 1'b0;
      read_data_valid <= 1'b0;
      read_bus_error <= 1'b0;
      write_data_accept <= 1'b0;
      write_bus_error <= 1'b0;
    end else begin
      cyc = cyc + 1;
      tog = ~tog;
      go = !slow || tog;
      if (read_data_valid) begin
        void'(rqa.pop_front());
        void'(rqt.pop_front());
      end
      write_bus_error <= 1'b0;
      if (write_data_accept) begin
        wlog.push_back({wq[0], write_data_out});
        write_bus_error <= err_en && wq[0][3:2] == err_idx;
        void'(wq.pop_front());
      end
      if (address_valid_out && address_accept_ready) begin
        if (write_not_read) wq.push_back(bus_address);
        else begin
          rqa.push_back(bus_address);
          rqt.push_back(cyc);
        end
      end
      // Ready low on alternate clocks when slow: the only throttle on addresses
      address_accept_ready <= go;
      // Earliest word lands two edges after its address take, legal for both kinds
      if (go && rqa.size() > 0 && rqt[0] < cyc) begin
        read_data_valid <= 1'b1;
        read_data_in <= rword(rqa[0]);
        read_bus_error <= err_en && rqa[0][3:2] == err_idx;
      end else begin
        read_data_valid <= 1'b0;
        read_data_in <= ~read_data_in; // Never leave a stale word showing
        read_bus_error <= 1'b0;
      end
      write_data_accept <= go && wq.size() > 0;
    end
  end
endmodule : bus_far_end

/* verif/core_system_bus_master_tb_top.sv */
// Bench for the system bus master against the far side model
`timescale 1ns/10ps
module core_system_bus_master_tb_top;
  logic clk, rst, req_valid, req_ready, req_write, req_instr, req_cacheable;
  logic [35:2] req_addr, bus_address;
  logic [3:0] req_be, byte_lane_enables;
  logic [127:0] req_wdata;
  logic [15:0] req_wbe;
  logic resp_valid, resp_write, resp_error, address_valid_out, address_accept_ready;
  logic write_not_read, instruction_fetch_flag, burst_indicator, burst_first_beat;
  logic burst_last_beat, subblock_order_select, read_data_valid, read_bus_error;
  logic write_data_accept, write_bus_error, slow, err_en, hv;
  logic [1:0] resp_index, err_idx;
  logic [31:0] resp_data, read_data_in, write_data_out;
  logic [42:0] beats[$];
  logic [35:0] resps[$];
  logic [42:0] held;
  int err_count, n_compared;

  core_system_bus_master u_core_system_bus_master (
    .clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_instr(req_instr), .req_cacheable(req_cacheable),
    .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata), .req_wbe(req_wbe),
    .resp_valid(resp_valid), .resp_write(resp_write), .resp_index(resp_index),
    .resp_data(resp_data), .resp_error(resp_error), .bus_address(bus_address),
    .byte_lane_enables(byte_lane_enables), .address_valid_out(address_valid_out),
    .address_accept_ready(address_accept_ready), .write_not_read(write_not_read),
    .instruction_fetch_flag(instruction_fetch_flag), .burst_indicator(burst_indicator),
    .burst_first_beat(burst_first_beat), .burst_last_beat(burst_last_beat),
    .subblock_order_select(subblock_order_select), .read_data_in(read_data_in),
    .read_data_valid(read_data_valid), .read_bus_error(read_bus_error),
    .write_data_out(write_data_out), .write_data_accept(write_data_accept),
    .write_bus_error(write_bus_error));

  bus_far_end u_far (
    .clk(clk), .rst(rst), .slow(slow), .err_en(err_en), .err_idx(err_idx),
    .bus_address(bus_address), .address_valid_out(address_valid_out),
    .write_not_read(write_not_read), .address_accept_ready(address_accept_ready),
    .read_data_in(read_data_in), .read_data_valid(read_data_valid),
    .read_bus_error(read_bus_error), .write_data_out(write_data_out),
    .write_data_accept(write_data_accept), .write_bus_error(write_bus_error));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] rword(input logic [35:2] a);
    return 32'h5A00_0000 ^ a[33:2];
  endfunction : rword

  function automatic logic [42:0] bt(input logic w, i, b, f, l, input logic [3:0] be,
      input logic [35:2] a);
    return {w, i, b, f, l, be, a};
  endfunction : bt

  function automatic logic [42:0] bus_beat();
    return bt(write_not_read, instruction_fetch_flag, burst_indicator, burst_first_beat,
      burst_last_beat, byte_lane_enables, bus_address);
  endfunction : bus_beat

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // Log address takes and responses; a stalled address must stand unchanged
  always @(posedge clk) begin
    if (!rst) begin
      if (hv) check({address_valid_out, bus_beat()}, {1'b1, held});
      hv <= address_valid_out && !address_accept_ready;
      held <= bus_beat();
      if (address_valid_out && address_accept_ready) beats.push_back(bus_beat());
      if (resp_valid) resps.push_back({resp_error, resp_write, resp_index, resp_data});
    end else hv <= 1'b0;
  end

  // One request, then wait (bounded) for the master to go idle again
  task automatic issue(input logic w, i, c, sb, input logic [35:2] a,
      input logic [3:0] be, input logic [127:0] wd, input logic [15:0] wbe);
    int n;
    beats.delete();
    resps.delete();
    u_far.wlog.delete();
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_instr <= i;
    req_cacheable <= c;
    subblock_order_select <= sb;
    req_addr <= a;
    req_be <= be;
    req_wdata <= wd;
    req_wbe <= wbe;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    // A master that never takes the request is a failure, not a skip
    if (req_ready !== 1'b1) begin
      err_count++;
      close_out();
    end
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (2) @(negedge clk);
    n = 0;
    while (req_ready !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (req_ready !== 1'b1) begin
      err_count++;
      close_out();
    end
    repeat (3) @(negedge clk);
  endtask : issue

  // Single reads: fetch flag, byte lanes, sampling, one error answer
  task automatic t_single_rd();
    logic [35:2] a;
    for (int k = 0; k < 4; k++) begin
      a = {32'h00AB_CD00, k[1:0]};
      slow = k[0];
      err_en = (k == 3);
      err_idx = 2'h3;
      issue(1'b0, k[1], 1'b0, 1'b0, a, 4'h1 << k, '0, '0);
      check(beats.size(), 1);
      check(beats[0], bt(1'b0, k[1], 1'b0, 1'b0, 1'b0, 4'h1 << k, a));
      check(resps[0], {k == 3, 1'b0, a[3:2], rword(a)});
    end
    $display("single read test done");
  endtask : t_single_rd

  // Burst reads: every start word in both orders, with stalls and errors
  task automatic t_burst_rd();
    logic [35:2] a, ea;
    logic [1:0] s, idx;
    logic sb;
    for (int m = 0; m < 8; m++) begin
      s = m[1:0];
      sb = m[2];
      a = {32'h0012_3450, s};
      slow = m[0];
      err_en = sb;
      err_idx = ~s;
      issue(1'b0, m[1], 1'b1, sb, a, 4'h0, '0, '0);
      check(beats.size(), 4);
      check(resps.size(), 4);
      for (int k = 0; k < 4; k++) begin
        idx = sb ? s ^ k[1:0] : s + k[1:0];
        ea = {a[35:4], idx};
        check(beats[k], bt(1'b0, m[1], 1'b1, k == 0, k == 3, 4'hF, ea));
        check(resps[k], {sb && idx == ~s, 1'b0, idx, rword(ea)});
      end
    end
    $display("burst read test done");
  endtask : t_burst_rd

  // Full block write: burst from word zero, stalled accepts, one error
  task automatic t_wr_burst();
    logic [127:0] wd;
    logic [35:2] a, ea;
    wd = 128'h4444_4444_3333_3333_2222_2222_1111_1111;
    a = {32'h0055_6600, 2'h2};
    slow = 1'b1;
    err_en = 1'b1;
    err_idx = 2'h1;
    issue(1'b1, 1'b0, 1'b0, 1'b0, a, 4'h0, wd, 16'hFFFF);
    check(beats.size(), 4);
    for (int k = 0; k < 4; k++) begin
      ea = {a[35:4], k[1:0]};
      check(beats[k], bt(1'b1, 1'b0, 1'b1, k == 0, k == 3, 4'hF, ea));
      check(u_far.wlog[k], {ea, wd[32*k +: 32]});
      check(resps[k], {k == 1, 1'b1, k[1:0], 32'h0});
    end
    $display("burst write test done");
  endtask : t_wr_burst

  // Partial block write: single writes for enabled words only
  task automatic t_wr_part();
    logic [127:0] wd;
    logic [15:0] wbe;
    logic [35:2] a, ea;
    int w;
    wd = 128'hDDDD_0004_CCCC_0003_BBBB_0002_AAAA_0001;
    wbe = 16'h30F0;
    a = {32'h0077_8800, 2'h0};
    slow = 1'b0;
    err_en = 1'b1;
    err_idx = 2'h3;
    issue(1'b1, 1'b0, 1'b0, 1'b0, a, 4'h0, wd, wbe);
    check(beats.size(), 2);
    for (int j = 0; j < 2; j++) begin
      w = j ? 3 : 1;
      ea = {a[35:4], w[1:0]};
      check(beats[j], bt(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, wbe[4*w +: 4], ea));
      check(u_far.wlog[j], {ea, wd[32*w +: 32]});
      check(resps[j], {w == 3, 1'b1, w[1:0], 32'h0});
    end
    $display("partial write test done");
  endtask : t_wr_part

  // Reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_instr = 1'b0;
    req_cacheable = 1'b0;
    req_addr = '0;
    req_be = 4'h0;
    req_wdata = '0;
    req_wbe = 16'h0;
    subblock_order_select = 1'b0;
    slow = 1'b0;
    err_en = 1'b0;
    err_idx = 2'h0;
    hv = 1'b0;
    err_count = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_single_rd();
    t_burst_rd();
    t_wr_burst();
    t_wr_part();
    close_out();
  end
endmodule : core_system_bus_master_tb_top
